// File: common/gpio_alt_pkg.sv
// shared constants, register map and state types for the gpio alternate-function block
package gpio_alt_pkg;

    localparam int NUM_PINS = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W = 8;

    localparam logic [ADDR_W-1:0] OFS_EDGE_FLAGS = 8'h0a;
    localparam logic [ADDR_W-1:0] OFS_ALT_SELECT = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_PIN_CFG_BASE = 8'h36;

    localparam int PIN_LOW_POWER = 0;
    localparam int PIN_SEQ_FIRST = 1;
    localparam int PIN_SEQ_LAST = 3;
    localparam int PIN_SLOW_CLOCK = 4;
    localparam int NUM_SEQ = 3;

    localparam logic [DATA_W-1:0] CFG_RESET = 8'h02;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ALT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    typedef enum logic [1:0] {
        EDGE_MASKED = 2'h0,
        EDGE_FALLING = 2'h1,
        EDGE_RISING = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_polarity_select_t;

    typedef enum logic [1:0] {
        DBNC_NONE = 2'h0,
        DBNC_SHORT = 2'h1,
        DBNC_MEDIUM = 2'h2,
        DBNC_LONG = 2'h3
    } debounce_setting_t;

    // one configuration byte per pin, msb first
    typedef struct packed {
        debounce_setting_t debounce_setting;
        edge_polarity_select_t edge_polarity_select;
        logic output_value;
        logic input_value;
        logic pin_direction;
        logic drive_type;
    } pin_cfg_t;

    typedef struct packed {
        pin_cfg_t [NUM_PINS-1:0] cfg;
        logic [NUM_PINS-1:0] alt_function_select;
        logic [NUM_PINS-1:0] pin_edge_flag;
        logic [NUM_PINS-1:0] deb;
        logic [NUM_PINS-1:0] deb_prev;
        logic [NUM_PINS-1:0][CNT_W-1:0] cnt;
        logic [DATA_W-1:0] rdata;
        logic otp_pending;
    } gpio_state_t;

endpackage

// File: test/gpio_alt_function_edge_irq_properties.sv
// port assertions for the gpio alternate-function block
`timescale 1ns/1ps
module gpio_alt_function_edge_irq_properties (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic shutdown_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n_out,
    input wire logic slow_clock_in,
    input wire logic low_power_req_out,
    input wire logic edge_pending_out
);
    localparam logic [7:0] FLG = gpio_alt_pkg::OFS_EDGE_FLAGS;
    localparam logic [7:0] ALT = gpio_alt_pkg::OFS_ALT_SELECT;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; reg_rd_in && reg_addr_in == 8'hff |=> reg_rdata_out == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_flag_read;
        reg_rd_in && reg_addr_in == FLG && edge_pending_out && !reg_wr_in && !shutdown_in
        |=> reg_rdata_out != 8'h00;
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("pending flag read as zero");
    property p_pend_hold;
        // a write that masks a pin clears its flag two cycles later
        edge_pending_out && !reg_rd_in && !reg_wr_in && !$past(reg_wr_in) && !shutdown_in
        |=> edge_pending_out;
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("flag lost without read");
    property p_shutdown;
        shutdown_in |=> !edge_pending_out && !low_power_req_out && pin_oe_n_out == 8'hff
        && reg_rdata_out == 8'h00;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown left state");
    property p_clk_follow;
        !$past(reg_wr_in) && !$past(shutdown_in) && $changed(pin_out[4])
        |-> pin_out[4] == slow_clock_in;
    endproperty
    a_clk_follow: assert property (p_clk_follow) else $error("pin 4 moved off clock");
    property p_alt_back;
        reg_wr_in && reg_addr_in == ALT && !shutdown_in ##1 !reg_wr_in && !shutdown_in
        ##1 reg_rd_in && reg_addr_in == ALT && !reg_wr_in && !shutdown_in
        |=> reg_rdata_out == $past(reg_wdata_in, 3);
    endproperty
    a_alt_back: assert property (p_alt_back) else $error("alt select readback");
    property p_rst_rel;
        $rose(rstn_in) |-> pin_oe_n_out == 8'hff && !edge_pending_out && !low_power_req_out;
    endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("reset state wrong");
endmodule // gpio_alt_function_edge_irq_properties

bind gpio_alt_function_edge_irq gpio_alt_function_edge_irq_properties i_props (
    .clk_in(clk_in), .rstn_in(rstn_in), .shutdown_in(shutdown_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n_out), .slow_clock_in(slow_clock_in),
    .low_power_req_out(low_power_req_out), .edge_pending_out(edge_pending_out));

// File: test/gpio_alt_function_edge_irq_tb_top.sv
// self-checking bench for the gpio alternate-function block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
module gpio_alt_function_edge_irq_tb_top;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic shutdown = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic slow = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] ext = 8'hff;
    logic [2:0] seq = 3'h0;
    logic [7:0] rdata, pin_out, oe_n, lvl;
    logic lp_req, pend;
    int err_total = 0;
    int n_compared = 0;
    always #10 clk_in = ~clk_in;
    gpio_alt_function_edge_irq i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .shutdown_in(shutdown), .alt_otp_in(8'h01), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .pin_in(lvl),
        .pin_out(pin_out), .pin_oe_n_out(oe_n), .slow_clock_in(slow), .seq_level_in(seq),
        .low_power_req_out(lp_req), .edge_pending_out(pend));
    gpio_board_model i_board (.pin_drv_in(pin_out), .pin_oe_n_in(oe_n), .ext_level_in(ext),
        .pin_level_out(lvl));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        `CHK(rdata, e)
    endtask
    task automatic close_out();
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        cyc(12);
        rstn_in = 1'b1;
        rd_reg(8'h0a, 8'h00);
        rd_reg(8'h40, 8'h01);
        rd_reg(8'h36, 8'h06);
        rd_reg(8'hff, 8'h00);
        wr_reg(8'h0a, 8'hff);
        wr_reg(8'h3b, 8'h09);
        `CHK({lvl[5], oe_n[5]}, 2'b10)
        wr_reg(8'h3b, 8'h00);
        `CHK({lvl[5], oe_n[5]}, 2'b00)
        wr_reg(8'h3b, 8'h08);
        `CHK(oe_n[5], 1'b1)
        for (int e = 0; e < 4; e++)
        begin
            wr_reg(8'h3c, {2'h0, 2'(e), 4'h2});
            ext[6] = 1'b0;
            cyc(3);
            rd_reg(8'h0a, {1'b0, e[0], 6'h00});
            ext[6] = 1'b1;
            cyc(3);
            rd_reg(8'h0a, {1'b0, e[1], 6'h00});
        end
        // pin change lands its flag on the very edge that takes the read
        ext[6] = 1'b0;
        rd_reg(8'h0a, 8'h00);
        rd_reg(8'h0a, 8'h40);
        wr_reg(8'h40, 8'h1f);
        rd_reg(8'h40, 8'h1f);
        for (int i = 1; i < 4; i++)
            wr_reg(8'h36 + 8'(i), 8'h01);
        seq = 3'h5;
        cyc(2);
        `CHK({lvl[3:1], oe_n[3:1]}, 6'h28)
        seq = 3'h2;
        cyc(2);
        `CHK(lvl[3:1], 3'h2)
        wr_reg(8'h3a, 8'h33);
        rd_reg(8'h3a, 8'h31);
        for (int k = 0; k < 4; k++)
        begin
            slow = ~slow;
            #1;
            `CHK({lvl[4], oe_n[4]}, {slow, 1'b0})
            cyc(1);
        end
        `CHK(pend, 1'b0)
        `CHK(lp_req, 1'b0)
        wr_reg(8'h36, 8'h00);
        `CHK(lp_req, 1'b1)
        ext[0] = 1'b0;
        cyc(3);
        `CHK({lp_req, oe_n[0]}, 2'b01)
        ext[6] = 1'b1;
        cyc(3);
        `CHK(pend, 1'b1)
        wr_reg(8'h3c, 8'h02);
        cyc(1);
        `CHK(pend, 1'b0)
        shutdown = 1'b1;
        cyc(1);
        shutdown = 1'b0;
        `CHK({pend, lp_req, oe_n}, 10'h0ff)
        cyc(2);
        rd_reg(8'h40, 8'h01);
        rd_reg(8'h3c, 8'h06);
        // short debounce: a 4-cycle glitch is filtered, a 12-cycle low is taken
        wr_reg(8'h3c, 8'h72);
        ext[6] = 1'b0;
        cyc(4);
        ext[6] = 1'b1;
        cyc(12);
        rd_reg(8'h0a, 8'h00);
        ext[6] = 1'b0;
        cyc(12);
        rd_reg(8'h0a, 8'h40);
        close_out();
    end
    // the sequence needs well under a thousand cycles; five thousand means a hang
    initial
    begin
        #100000;
        err_total++;
        close_out();
    end
endmodule // gpio_alt_function_edge_irq_tb_top

// File: test/gpio_board_model.sv
// board model: levels on the eight pins
`timescale 1ns/1ps
module gpio_board_model (
    input wire logic [7:0] pin_drv_in,
    input wire logic [7:0] pin_oe_n_in,
    input wire logic [7:0] ext_level_in,
    output logic [7:0] pin_level_out
);
    // a released pin shows the board level; the bench keeps it pulled high when idle
    assign pin_level_out = (~pin_oe_n_in & pin_drv_in) | (pin_oe_n_in & ext_level_in);
endmodule // gpio_board_model

// File: verilog/gpio_alt_function_edge_irq.sv
// gpio alternate-function selection, pin drive and read-clear edge flags
`timescale 1ns/1ps

module gpio_alt_function_edge_irq #(
    parameter logic [gpio_alt_pkg::CNT_W-1:0] DBNC_SHORT_CYC = 8'h08,
    parameter logic [gpio_alt_pkg::CNT_W-1:0] DBNC_MEDIUM_CYC = 8'h20,
    parameter logic [gpio_alt_pkg::CNT_W-1:0] DBNC_LONG_CYC = 8'h80
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic shutdown_in,
    input wire logic [gpio_alt_pkg::NUM_PINS-1:0] alt_otp_in,
    input wire logic [gpio_alt_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [gpio_alt_pkg::DATA_W-1:0] reg_wdata_in,
    output logic [gpio_alt_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic [gpio_alt_pkg::NUM_PINS-1:0] pin_in,
    output logic [gpio_alt_pkg::NUM_PINS-1:0] pin_out,
    output logic [gpio_alt_pkg::NUM_PINS-1:0] pin_oe_n_out,
    input wire logic slow_clock_in,
    input wire logic [gpio_alt_pkg::NUM_SEQ-1:0] seq_level_in,
    output logic low_power_req_out,
    output logic edge_pending_out
);

    localparam gpio_alt_pkg::gpio_state_t ST_RESET = '{
        cfg: {gpio_alt_pkg::NUM_PINS{gpio_alt_pkg::CFG_RESET}},
        alt_function_select: gpio_alt_pkg::ALT_RESET,
        pin_edge_flag: gpio_alt_pkg::FLAGS_RESET,
        rdata: gpio_alt_pkg::READ_IDLE,
        otp_pending: 1'b1,
        default: '0
    };

    gpio_alt_pkg::gpio_state_t st_ff;
    gpio_alt_pkg::gpio_state_t nxt_st;

    // hit on a per-pin configuration register, index returned through cfg_index
    function automatic logic cfg_hit(input logic [gpio_alt_pkg::ADDR_W-1:0] addr);
        cfg_hit = (addr >= gpio_alt_pkg::OFS_PIN_CFG_BASE) &&
                  (addr < gpio_alt_pkg::OFS_PIN_CFG_BASE + gpio_alt_pkg::ADDR_W'(gpio_alt_pkg::NUM_PINS));
    endfunction

    function automatic logic [2:0] cfg_index(input logic [gpio_alt_pkg::ADDR_W-1:0] addr);
        logic [gpio_alt_pkg::ADDR_W-1:0] diff;
        diff = addr - gpio_alt_pkg::OFS_PIN_CFG_BASE;
        cfg_index = diff[2:0];
    endfunction

    function automatic logic [gpio_alt_pkg::CNT_W-1:0] dbnc_limit(
        input gpio_alt_pkg::debounce_setting_t sel
    );
        unique case (sel)
            gpio_alt_pkg::DBNC_SHORT: dbnc_limit = DBNC_SHORT_CYC;
            gpio_alt_pkg::DBNC_MEDIUM: dbnc_limit = DBNC_MEDIUM_CYC;
            gpio_alt_pkg::DBNC_LONG: dbnc_limit = DBNC_LONG_CYC;
            gpio_alt_pkg::DBNC_NONE: dbnc_limit = '0;
        endcase
    endfunction

    // clock-output mode of pin 4
    function automatic logic slow_clock_mode(
        input logic [gpio_alt_pkg::NUM_PINS-1:0] alt,
        input int idx
    );
        slow_clock_mode = (idx == gpio_alt_pkg::PIN_SLOW_CLOCK) && alt[idx];
    endfunction

    // sequencer-output mode of pins 1 to 3
    function automatic logic seq_out_mode(
        input logic [gpio_alt_pkg::NUM_PINS-1:0] alt,
        input int idx
    );
        seq_out_mode = (idx >= gpio_alt_pkg::PIN_SEQ_FIRST) &&
                       (idx <= gpio_alt_pkg::PIN_SEQ_LAST) && alt[idx];
    endfunction

    // low-power control input mode of pin 0
    function automatic logic low_power_mode(
        input logic [gpio_alt_pkg::NUM_PINS-1:0] alt,
        input int idx
    );
        low_power_mode = (idx == gpio_alt_pkg::PIN_LOW_POWER) && alt[idx];
    endfunction

    // configuration byte as software sees it, with debounced input level except in clock mode, where input and direction read 0
    function automatic logic [gpio_alt_pkg::DATA_W-1:0] cfg_view(
        input gpio_alt_pkg::gpio_state_t s,
        input logic [2:0] idx
    );
        gpio_alt_pkg::pin_cfg_t c;
        c = s.cfg[idx];
        c.input_value = s.deb[idx];
        if (slow_clock_mode(s.alt_function_select, int'(idx)))
        begin
            c.input_value = 1'b0;
            c.pin_direction = 1'b0;
        end
        cfg_view = c;
    endfunction

    always_comb
    begin
        logic [gpio_alt_pkg::NUM_PINS-1:0] set_v;
        logic [gpio_alt_pkg::NUM_PINS-1:0] clr_v;
        logic rise;
        logic fall;
        logic hit;
        logic [2:0] widx;
        gpio_alt_pkg::pin_cfg_t wcfg;
        set_v = '0;
        clr_v = '0;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        widx = cfg_index(reg_addr_in);
        wcfg = reg_wdata_in;
        nxt_st = st_ff;

        for (int i = 0; i < gpio_alt_pkg::NUM_PINS; i++)
        begin
            // debounce filter; clock mode bypasses it so the pin loop is not filtered
            if (st_ff.cfg[i].debounce_setting == gpio_alt_pkg::DBNC_NONE ||
                slow_clock_mode(st_ff.alt_function_select, i))
            begin
                nxt_st.deb[i] = pin_in[i];
                nxt_st.cnt[i] = '0;
            end
            else if (pin_in[i] != st_ff.deb[i])
            begin
                if (st_ff.cnt[i] >= dbnc_limit(st_ff.cfg[i].debounce_setting))
                begin
                    nxt_st.deb[i] = pin_in[i];
                    nxt_st.cnt[i] = '0;
                end
                else
                begin
                    nxt_st.cnt[i] = st_ff.cnt[i] + 1'b1;
                end
            end
            else
            begin
                nxt_st.cnt[i] = '0;
            end
            nxt_st.deb_prev[i] = st_ff.deb[i];

            rise = st_ff.deb[i] & ~st_ff.deb_prev[i];
            fall = ~st_ff.deb[i] & st_ff.deb_prev[i];
            unique case (st_ff.cfg[i].edge_polarity_select)
                gpio_alt_pkg::EDGE_FALLING: hit = fall;
                gpio_alt_pkg::EDGE_RISING: hit = rise;
                gpio_alt_pkg::EDGE_BOTH: hit = rise | fall;
                gpio_alt_pkg::EDGE_MASKED: hit = 1'b0;
            endcase
            // sequencer pins rely on software zeroing the edge field
            if (slow_clock_mode(st_ff.alt_function_select, i))
            begin
                hit = 1'b0;
            end
            set_v[i] = hit;
        end

        // read data comes from a register one cycle after the strobe
        nxt_st.rdata = gpio_alt_pkg::READ_IDLE;
        if (reg_rd_in)
        begin
            if (reg_addr_in == gpio_alt_pkg::OFS_EDGE_FLAGS)
            begin
                nxt_st.rdata = st_ff.pin_edge_flag;
                clr_v = '1;
            end
            else if (reg_addr_in == gpio_alt_pkg::OFS_ALT_SELECT)
            begin
                nxt_st.rdata = st_ff.alt_function_select;
            end
            else if (cfg_hit(reg_addr_in))
            begin
                nxt_st.rdata = cfg_view(st_ff, widx);
            end
        end

        // set beats clear so an edge in the read cycle is kept
        nxt_st.pin_edge_flag = (st_ff.pin_edge_flag & ~clr_v) | set_v;
        for (int i = 0; i < gpio_alt_pkg::NUM_PINS; i++)
        begin
            if (st_ff.cfg[i].edge_polarity_select == gpio_alt_pkg::EDGE_MASKED)
            begin
                nxt_st.pin_edge_flag[i] = 1'b0;
            end
        end

        // strap is caught one cycle after reset or shutdown; writes then override it
        nxt_st.otp_pending = 1'b0;
        if (st_ff.otp_pending)
        begin
            nxt_st.alt_function_select = alt_otp_in;
            // filters start cleared while pins may sit high; take the pins as they are
            // so that no false edge follows reset or shutdown
            nxt_st.deb = pin_in;
            nxt_st.deb_prev = pin_in;
        end

        if (reg_wr_in)
        begin
            if (reg_addr_in == gpio_alt_pkg::OFS_ALT_SELECT)
            begin
                nxt_st.alt_function_select = reg_wdata_in;
            end
            else if (cfg_hit(reg_addr_in))
            begin
                wcfg.input_value = 1'b0;
                nxt_st.cfg[widx] = wcfg;
            end
        end

        if (shutdown_in)
        begin
            nxt_st = ST_RESET;
        end
    end

    // one register stage for all state; shutdown is handled in the next-state logic
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_ff <= ST_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // pin drive: open-drain releases the pin for a high level
    always_comb
    begin
        logic is_out;
        logic val;
        logic push_pull;
        logic [gpio_alt_pkg::NUM_PINS-1:0] seq_at_pin;
        is_out = 1'b0;
        val = 1'b0;
        push_pull = 1'b0;
        // sequencer levels lined up with the pins they drive
        seq_at_pin = gpio_alt_pkg::NUM_PINS'(seq_level_in) << gpio_alt_pkg::PIN_SEQ_FIRST;
        pin_out = '0;
        pin_oe_n_out = '1;
        for (int i = 0; i < gpio_alt_pkg::NUM_PINS; i++)
        begin
            push_pull = st_ff.cfg[i].drive_type;
            if (slow_clock_mode(st_ff.alt_function_select, i))
            begin
                is_out = 1'b1;
                val = slow_clock_in;
            end
            else if (seq_out_mode(st_ff.alt_function_select, i))
            begin
                is_out = 1'b1;
                val = seq_at_pin[i];
            end
            else if (low_power_mode(st_ff.alt_function_select, i))
            begin
                is_out = 1'b0;
                val = 1'b0;
            end
            else
            begin
                is_out = ~st_ff.cfg[i].pin_direction;
                val = st_ff.cfg[i].output_value;
            end
            pin_out[i] = push_pull ? val : 1'b0;
            pin_oe_n_out[i] = ~(is_out & (push_pull | ~val));
        end
    end

    // direction high makes the control input active-low
    assign low_power_req_out =
        low_power_mode(st_ff.alt_function_select, gpio_alt_pkg::PIN_LOW_POWER) &
        (st_ff.deb[gpio_alt_pkg::PIN_LOW_POWER] ^
         st_ff.cfg[gpio_alt_pkg::PIN_LOW_POWER].pin_direction);
    // one summary line for the interrupt aggregator; software reads the detail
    assign edge_pending_out = |st_ff.pin_edge_flag;
    // idle read data is zero so several targets can share one return path
    assign reg_rdata_out = st_ff.rdata;

endmodule // gpio_alt_function_edge_irq
